/* File: bsse_pkg.sv */
// Package with constants, types and register map for the setpoint step engine
package bsse_pkg;

  localparam int WW = 24;
  localparam int NSTEP = 8;
  localparam int SW = 3;
  localparam int NOUT = 8;

  // Step kinds
  typedef enum logic [3:0] {
    KIND_OFF = 4'h0,
    KIND_WEIGHT = 4'h1,
    KIND_WAIT_STANDSTILL = 4'h2,
    KIND_REPEAT = 4'h3,
    KIND_NUDGE = 4'h4,
    KIND_CLOCK = 4'h5,
    KIND_DELTA = 4'h6,
    KIND_TRUE = 4'h7,
    KIND_FALSE = 4'h8
  } bsse_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_PULSE = 2'b11
  } bsse_state_t;

  typedef struct packed {
    logic standstill;
    logic zeroCenter;
    logic capacity_range_monitor;
    logic [WW-1:0] weight;
  } bsse_scale_t;

  // Register offsets, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_REPEAT = 8'h10;
  localparam logic [7:0] OFF_NUDGE = 8'h14;
  localparam logic [7:0] OFF_WDOG = 8'h18;
  localparam logic [7:0] OFF_WDSE = 8'h1C;
  localparam logic [7:0] OFF_TIME = 8'h20;
  localparam logic [7:0] OFF_CLKSET = 8'h24;
  localparam logic [7:0] OFF_OVER = 8'h28;
  localparam logic [7:0] OFF_UNDER = 8'h2C;
  localparam logic [7:0] OFF_OUTMAP = 8'h30;
  localparam logic [7:0] OFF_STEP0 = 8'h40;

  // Control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;

  // Interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WDOG = 1;
  localparam int IRQ_CLOCK = 2;
  localparam int IRQ_NUDGE = 3;
  localparam int NIRQ = 4;

  // Timing: one tenth of a second in ns and in cycles at 100 MHz
  localparam longint TENTH_NS = 100000000;
  localparam longint CLK_NS = 10;
  localparam int TENTH_CYC = int'(TENTH_NS / CLK_NS);

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

/* File: bsse_engine.sv */
// Batch and continuous setpoint step engine with APB register access
// How it works
// - Wait-standstill step holds until standstill
// - Repeat step passes; off or last step runs sequence configured times
// - Nudge pulses previous weight output if short
// - Nudge repeats until satisfied at standstill
// - Zero-center monitor output follows zero flag
// - Motion monitor output active when not standstill
// - Range monitor output follows in-range flag
// - Batch-active output high during sequence
// - Watchdog times start to end in tenths
// - Watchdog output set when limit elapses
// - Clock-match step acts when time equals
// - Delta step satisfied when change reaches value
// - Check weigher drives the over line; under and accept are status bits only
// - True step always satisfied
// - False step never satisfied, branches
// - Non-batch weight setpoint acts continuously
`timescale 1ns/1ps
`default_nettype none
module bsse_engine #(
  parameter int TENTH_CYCLES = bsse_pkg::TENTH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bsse_pkg::bsse_scale_t scale,
  output logic [bsse_pkg::NOUT-1:0] digOut,
  output logic irq
);

  localparam int WW = bsse_pkg::WW;
  localparam int NS = bsse_pkg::NSTEP;
  localparam int SW = bsse_pkg::SW;

  // Step table: kind[3:0], batch flag[4], out line[7:5], branch[10:8], value[31:11]
  logic [31:0] stepReg [NS];
  logic [31:0] ctrlWrite;
  logic [15:0] repeatCfgReg;
  logic [15:0] nudgeCfgReg;
  logic [15:0] wdogLimitReg;
  logic [5:0] wdogSeReg;
  logic [16:0] timeReg;
  logic [16:0] clockSetReg;
  logic [WW-1:0] overReg;
  logic [WW-1:0] underReg;
  logic [17:0] outMapReg;
  logic [bsse_pkg::NIRQ-1:0] irqStatReg;
  logic [bsse_pkg::NIRQ-1:0] irqMaskReg;
  bsse_pkg::bsse_state_t stateReg;
  logic [SW-1:0] stepIdxReg;
  logic [15:0] passCntReg;
  logic [WW-1:0] deltaBaseReg;
  logic [15:0] pulseTenthReg;
  logic [31:0] tickCntReg;
  logic tickPulse;
  logic wdogRunReg;
  logic wdogFiredReg;
  logic [15:0] wdogCntReg;
  logic [SW-1:0] prevWeightReg;
  logic [NS-1:0] stepOutReg;

  logic apbWr;
  logic apbRd;
  logic startReq;
  logic abortReq;
  bsse_pkg::bsse_kind_t curKind;
  logic [WW-1:0] curTarget;
  logic [SW-1:0] curBranch;
  logic [WW-1:0] prevTarget;
  logic prevSat;
  logic curSat;
  logic [WW-1:0] deltaAbs;
  logic lastStep;
  logic clockHit;
  logic batchActive;
  logic doneEvt;
  logic wdogEvt;
  logic nudgeEvt;

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign startReq = apbWr && paddr == bsse_pkg::OFF_CTRL && pwdata[bsse_pkg::CTRL_START];
  assign abortReq = apbWr && paddr == bsse_pkg::OFF_CTRL && pwdata[bsse_pkg::CTRL_ABORT];
  assign ctrlWrite = pwdata;

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      repeatCfgReg <= 16'h0001;
      nudgeCfgReg <= 16'h0001;
      wdogLimitReg <= 16'h0000;
      wdogSeReg <= 6'h00;
      clockSetReg <= 17'h00000;
      overReg <= '0;
      underReg <= '0;
      outMapReg <= 18'h00000;
      irqMaskReg <= '0;
      for (int i = 0; i < NS; i++) begin
        stepReg[i] <= bsse_pkg::RST_ZERO;
      end
    end else if (apbWr) begin
      unique case (paddr)
        bsse_pkg::OFF_REPEAT: repeatCfgReg <= ctrlWrite[15:0];
        bsse_pkg::OFF_NUDGE: nudgeCfgReg <= ctrlWrite[15:0];
        bsse_pkg::OFF_WDOG: wdogLimitReg <= ctrlWrite[15:0];
        bsse_pkg::OFF_WDSE: wdogSeReg <= ctrlWrite[5:0];
        bsse_pkg::OFF_CLKSET: clockSetReg <= ctrlWrite[16:0];
        bsse_pkg::OFF_OVER: overReg <= ctrlWrite[WW-1:0];
        bsse_pkg::OFF_UNDER: underReg <= ctrlWrite[WW-1:0];
        bsse_pkg::OFF_OUTMAP: outMapReg <= ctrlWrite[17:0];
        bsse_pkg::OFF_MASK: irqMaskReg <= ctrlWrite[bsse_pkg::NIRQ-1:0];
        default: begin
          if (paddr[7:5] == 3'h2 && paddr[1:0] == 2'h0) begin
            stepReg[paddr[4:2]] <= ctrlWrite;
          end
        end
      endcase
    end
  end

  // Tenth-second tick and time-of-day seconds counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCntReg <= 32'h0000_0000;
      tickPulse <= 1'b0;
    end else if (tickCntReg == 32'(TENTH_CYCLES - 1)) begin
      tickCntReg <= 32'h0000_0000;
      tickPulse <= 1'b1;
    end else begin
      tickCntReg <= tickCntReg + 32'h0000_0001;
      tickPulse <= 1'b0;
    end
  end

  logic [3:0] tenthsReg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeReg <= 17'h00000;
      tenthsReg <= 4'h0;
    end else if (apbWr && paddr == bsse_pkg::OFF_TIME) begin
      timeReg <= ctrlWrite[16:0];
      tenthsReg <= 4'h0;
    end else if (tickPulse) begin
      if (tenthsReg == 4'h9) begin
        tenthsReg <= 4'h0;
        timeReg <= (timeReg == 17'h1517F) ? 17'h00000 : timeReg + 17'h00001;
      end else begin
        tenthsReg <= tenthsReg + 4'h1;
      end
    end
  end

  // Decode of the active step
  assign curKind = bsse_pkg::bsse_kind_t'(stepReg[stepIdxReg][3:0]);
  assign curTarget = WW'(stepReg[stepIdxReg][31:11]);
  assign curBranch = stepReg[stepIdxReg][10:8];
  assign prevTarget = WW'(stepReg[prevWeightReg][31:11]);
  assign prevSat = scale.weight >= prevTarget;
  assign deltaAbs = (scale.weight >= deltaBaseReg) ? scale.weight - deltaBaseReg
                                                   : deltaBaseReg - scale.weight;
  assign clockHit = timeReg == clockSetReg;
  assign lastStep = stepIdxReg == SW'(NS - 1);
  assign batchActive = stateReg != bsse_pkg::ST_IDLE;

  always_comb begin
    curSat = 1'b0;
    unique case (curKind)
      bsse_pkg::KIND_WAIT_STANDSTILL: curSat = scale.standstill;
      bsse_pkg::KIND_WEIGHT: curSat = scale.weight >= curTarget;
      bsse_pkg::KIND_CLOCK: curSat = clockHit;
      bsse_pkg::KIND_DELTA: curSat = deltaAbs >= curTarget;
      bsse_pkg::KIND_TRUE: curSat = 1'b1;
      bsse_pkg::KIND_FALSE: curSat = 1'b0;
      bsse_pkg::KIND_REPEAT: curSat = 1'b1;
      bsse_pkg::KIND_NUDGE: curSat = scale.standstill && prevSat;
      default: curSat = 1'b1;
    endcase
  end

  // Batch sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= bsse_pkg::ST_IDLE;
      stepIdxReg <= '0;
      passCntReg <= 16'h0000;
      deltaBaseReg <= '0;
      pulseTenthReg <= 16'h0000;
      prevWeightReg <= '0;
      doneEvt <= 1'b0;
      nudgeEvt <= 1'b0;
    end else begin
      doneEvt <= 1'b0;
      nudgeEvt <= 1'b0;
      if (abortReq) begin
        stateReg <= bsse_pkg::ST_IDLE;
      end else begin
        unique case (stateReg)
          bsse_pkg::ST_IDLE: begin
            if (startReq) begin
              stateReg <= bsse_pkg::ST_EVAL;
              stepIdxReg <= '0;
              passCntReg <= 16'h0000;
              deltaBaseReg <= scale.weight;
            end
          end
          bsse_pkg::ST_EVAL: begin
            // nudge pulse on unsatisfied setpoint at standstill
            if (curKind == bsse_pkg::KIND_NUDGE && scale.standstill && !prevSat) begin
              stateReg <= bsse_pkg::ST_PULSE;
              pulseTenthReg <= nudgeCfgReg;
              nudgeEvt <= 1'b1;
            end else if (curKind == bsse_pkg::KIND_FALSE) begin
              stepIdxReg <= curBranch;
              deltaBaseReg <= scale.weight;
            end else if (curSat) begin
              if (curKind == bsse_pkg::KIND_WEIGHT) begin
                prevWeightReg <= stepIdxReg;
              end
              deltaBaseReg <= scale.weight;
              if (lastStep || curKind == bsse_pkg::KIND_OFF) begin
                if (passCntReg + 16'h0001 >= repeatCfgReg) begin
                  stateReg <= bsse_pkg::ST_IDLE;
                  doneEvt <= 1'b1;
                end else begin
                  passCntReg <= passCntReg + 16'h0001;
                  stepIdxReg <= '0;
                end
              end else begin
                stepIdxReg <= stepIdxReg + SW'(1);
              end
            end
          end
          bsse_pkg::ST_PULSE: begin
            if (tickPulse) begin
              if (pulseTenthReg <= 16'h0001) begin
                stateReg <= bsse_pkg::ST_EVAL;
              end else begin
                pulseTenthReg <= pulseTenthReg - 16'h0001;
              end
            end
          end
          default: stateReg <= bsse_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // watchdog between start and end steps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdogRunReg <= 1'b0;
      wdogCntReg <= 16'h0000;
      wdogFiredReg <= 1'b0;
      wdogEvt <= 1'b0;
    end else begin
      wdogEvt <= 1'b0;
      if (!batchActive || stepIdxReg == wdogSeReg[5:3]) begin
        wdogRunReg <= 1'b0;
        if (!batchActive && startReq) begin
          wdogFiredReg <= 1'b0;
        end
      end else if (stepIdxReg == wdogSeReg[2:0] && !wdogRunReg && !wdogFiredReg) begin
        wdogRunReg <= 1'b1;
        wdogCntReg <= 16'h0000;
      end else if (wdogRunReg && tickPulse) begin
        if (wdogCntReg + 16'h0001 >= wdogLimitReg) begin
          wdogRunReg <= 1'b0;
          wdogFiredReg <= 1'b1;
          wdogEvt <= 1'b1;
        end else begin
          wdogCntReg <= wdogCntReg + 16'h0001;
        end
      end
    end
  end

  // per-step output: weight steps continuous when batch flag off
  for (genvar g = 0; g < NS; g++) begin : gStepOut
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stepOutReg[g] <= 1'b0;
      end else if (stepReg[g][3:0] != 4'(bsse_pkg::KIND_WEIGHT)) begin
        stepOutReg[g] <= (stateReg == bsse_pkg::ST_PULSE) && prevWeightReg == SW'(g);
      end else if (!stepReg[g][4]) begin
        stepOutReg[g] <= scale.weight < WW'(stepReg[g][31:11]);
      end else begin
        // nudge drives the previous weight output
        stepOutReg[g] <= (batchActive && stepIdxReg == SW'(g) && stateReg == bsse_pkg::ST_EVAL)
          || ((stateReg == bsse_pkg::ST_PULSE) && prevWeightReg == SW'(g));
      end
    end
  end

  // Monitor outputs: out map holds lines, 3 bits each
  logic [bsse_pkg::NOUT-1:0] outNext;
  always_comb begin
    outNext = '0;
    for (int s = 0; s < NS; s++) begin
      outNext[stepReg[s][7:5]] = outNext[stepReg[s][7:5]] | stepOutReg[s];
    end
    outNext[outMapReg[2:0]] = outNext[outMapReg[2:0]] | scale.zeroCenter;
    outNext[outMapReg[5:3]] = outNext[outMapReg[5:3]] | !scale.standstill;
    outNext[outMapReg[8:6]] = outNext[outMapReg[8:6]] | scale.capacity_range_monitor;
    outNext[outMapReg[11:9]] = outNext[outMapReg[11:9]] | batchActive;
    outNext[outMapReg[14:12]] = outNext[outMapReg[14:12]] | wdogFiredReg;
    outNext[outMapReg[17:15]] = outNext[outMapReg[17:15]] | (scale.weight > overReg);
  end

  logic chkUnder;
  logic chkAccept;
  assign chkUnder = scale.weight < underReg;
  assign chkAccept = !chkUnder && !(scale.weight > overReg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digOut <= '0;
    end else begin
      digOut <= outNext;
    end
  end

  // Sticky interrupt status, cleared by read, set wins
  logic [bsse_pkg::NIRQ-1:0] irqSet;
  assign irqSet = {nudgeEvt, clockHit && tickPulse, wdogEvt, doneEvt};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatReg <= '0;
    end else if (apbRd && paddr == bsse_pkg::OFF_IRQ) begin
      // Clear only the bits the read returned
      irqStatReg <= (irqStatReg & ~prdata[bsse_pkg::NIRQ-1:0]) | irqSet;
    end else begin
      irqStatReg <= irqStatReg | irqSet;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatReg & irqMaskReg);
    end
  end

  // APB read data and answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          bsse_pkg::OFF_CTRL: prdata <= 32'h0000_0000;
          bsse_pkg::OFF_STATUS: prdata <= {13'h0000, chkAccept, chkUnder, wdogFiredReg,
                                           passCntReg[7:0], 2'h0, stepIdxReg, 1'h0,
                                           stateReg};
          bsse_pkg::OFF_IRQ: prdata <= 32'(irqStatReg);
          bsse_pkg::OFF_MASK: prdata <= 32'(irqMaskReg);
          bsse_pkg::OFF_REPEAT: prdata <= 32'(repeatCfgReg);
          bsse_pkg::OFF_NUDGE: prdata <= 32'(nudgeCfgReg);
          bsse_pkg::OFF_WDOG: prdata <= 32'(wdogLimitReg);
          bsse_pkg::OFF_WDSE: prdata <= 32'(wdogSeReg);
          bsse_pkg::OFF_TIME: prdata <= 32'(timeReg);
          bsse_pkg::OFF_CLKSET: prdata <= 32'(clockSetReg);
          bsse_pkg::OFF_OVER: prdata <= 32'(overReg);
          bsse_pkg::OFF_UNDER: prdata <= 32'(underReg);
          bsse_pkg::OFF_OUTMAP: prdata <= 32'(outMapReg);
          default: begin
            if (paddr[7:5] == 3'h2 && paddr[1:0] == 2'h0) begin
              prdata <= stepReg[paddr[4:2]];
            end else begin
              prdata <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: bsse_checker.sv */
// Port checker for the setpoint step engine
`timescale 1ns/1ps
`default_nettype none
module bsse_checker #(
  parameter int TENTH_CYCLES = bsse_pkg::TENTH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire bsse_pkg::bsse_scale_t scale,
  input wire logic [bsse_pkg::NOUT-1:0] digOut,
  input wire logic irq
);
  logic wr;
  logic [31:0] map_reg, over_reg, mask_reg;
  logic [1:0] age_reg;
  assign wr = psel && penable && pready && pwrite;
  // Shadow copies of the written maps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_reg <= 32'h0000_0000;
      over_reg <= 32'h0000_0000;
      mask_reg <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == bsse_pkg::OFF_OUTMAP) map_reg <= pwdata;
      if (paddr == bsse_pkg::OFF_OVER) over_reg <= pwdata;
      if (paddr == bsse_pkg::OFF_MASK) mask_reg <= pwdata;
    end
  end
  // Cycles since the line map or over limit last changed, held at 3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= 2'h0;
    end else if (wr && (paddr == bsse_pkg::OFF_OUTMAP || paddr == bsse_pkg::OFF_OVER)) begin
      age_reg <= 2'h1;
    end else if (age_reg != 2'h0 && age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready;
    psel && !penable |=> penable && pready;
  endproperty
  a_ready: assert property (p_ready) else $error("No ready in access cycle");
  property p_pulse;
    pready |-> penable ##1 !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Ready not a single pulse");
  property p_err;
    pready |-> !pslverr;
  endproperty
  a_err: assert property (p_err) else $error("Slave error raised");
  property p_rst;
    $rose(rst_n) |-> digOut == 8'h00 && !irq && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("Outputs not clear after reset");
  property p_zero;
    age_reg == 2'h3 |-> digOut[map_reg[2:0]] == $past(scale.zeroCenter);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero line wrong");
  property p_move;
    age_reg == 2'h3 |-> digOut[map_reg[5:3]] == !$past(scale.standstill);
  endproperty
  a_move: assert property (p_move) else $error("Motion line wrong");
  property p_range;
    age_reg == 2'h3 |-> digOut[map_reg[8:6]] == $past(scale.capacity_range_monitor);
  endproperty
  a_range: assert property (p_range) else $error("Range line wrong");
  property p_over;
    age_reg == 2'h3 && $past(scale.weight) != over_reg[23:0]
      |-> digOut[map_reg[17:15]] == ($past(scale.weight) > over_reg[23:0]);
  endproperty
  a_over: assert property (p_over) else $error("Over line wrong");
  property p_mask;
    mask_reg == 32'h0000_0000 && $past(mask_reg) == 32'h0000_0000 |-> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("Interrupt while all masked");
  c_write: cover property (wr);
  c_batch: cover property (age_reg == 2'h3 && digOut[map_reg[11:9]]);
  c_irq: cover property (irq);
endmodule
bind bsse_engine bsse_checker #(.TENTH_CYCLES(TENTH_CYCLES)) chk_u (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scale(scale), .digOut(digOut),
  .irq(irq));
`default_nettype wire

/* File: bsse_front_model.sv */
// Weighing front end model with a feed that fills while its line is on
`timescale 1ns/1ps
`default_nettype none
module bsse_front_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] digOut,
  input wire logic [2:0] feedLine,
  input wire logic [23:0] setWt,
  input wire logic setEn,
  input wire logic moveIn,
  input wire logic zeroIn,
  input wire logic rangeIn,
  output var bsse_pkg::bsse_scale_t scale
);
  logic [23:0] wt_reg;
  logic [1:0] quiet_reg;
  logic feed;
  assign feed = digOut[feedLine];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wt_reg <= 24'h00_0000;
      quiet_reg <= 2'h0;
    end else begin
      wt_reg <= setEn ? setWt : wt_reg + (feed ? 24'h00_0005 : 24'h00_0000);
      quiet_reg <= feed ? 2'h3 : quiet_reg - {1'b0, quiet_reg != 2'h0};
    end
  end
  // Reading runs high while feeding, settles after
  always_comb begin
    scale.standstill = !moveIn && !feed && quiet_reg == 2'h0;
    scale.zeroCenter = zeroIn;
    scale.capacity_range_monitor = rangeIn;
    scale.weight = wt_reg + (feed ? 24'h00_0032 : 24'h00_0000);
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the setpoint step engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq;
  bsse_pkg::bsse_scale_t scale;
  logic [7:0] digOut;
  logic [23:0] setWt = 24'h00_0000;
  logic setEn = 1'b1, moveIn = 1'b0, zeroIn = 1'b0, rangeIn = 1'b0;
  logic [23:0] wts [3] = '{24'h00_00FA, 24'h00_0096, 24'h00_0032};
  logic [31:0] cws [3] = '{32'h0000_0000, 32'h0004_0000, 32'h0002_0000};
  int fails = 0;
  int compares = 0;
  always #5 clk = ~clk;
  bsse_engine #(.TENTH_CYCLES(10)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scale(scale), .digOut(digOut), .irq(irq));
  bsse_front_model model_u (.clk(clk), .rst_n(rst_n), .digOut(digOut), .feedLine(3'h6),
    .setWt(setWt), .setEn(setEn), .moveIn(moveIn), .zeroIn(zeroIn), .rangeIn(rangeIn),
    .scale(scale));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd & m);
  endtask
  task automatic waitIrq();
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  task automatic run(input logic [31:0] s0, s1, s2, msk);
    apb(1'b1, 8'h40, s0);
    apb(1'b1, 8'h44, s1);
    apb(1'b1, 8'h48, s2);
    apb(1'b1, 8'h4C, 32'h0000_0000);
    apb(1'b1, bsse_pkg::OFF_MASK, msk);
    apb(1'b1, bsse_pkg::OFF_CTRL, 32'h0000_0001);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdChk("repeat reset", bsse_pkg::OFF_REPEAT, 32'hFFFF_FFFF, 32'h0000_0001);
    rdChk("nudge reset", bsse_pkg::OFF_NUDGE, 32'hFFFF_FFFF, 32'h0000_0001);
    rdChk("mask reset", bsse_pkg::OFF_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdChk("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("Test reset done");
    apb(1'b1, bsse_pkg::OFF_WDOG, 32'h0000_00FF);
    apb(1'b1, bsse_pkg::OFF_WDSE, 32'h0000_0008);
    apb(1'b1, bsse_pkg::OFF_OVER, 32'h0000_00C8);
    apb(1'b1, bsse_pkg::OFF_UNDER, 32'h0000_0064);
    apb(1'b1, bsse_pkg::OFF_OUTMAP, 32'h0002_C688);
    for (int i = 0; i < 8; i++) begin
      {moveIn, zeroIn, rangeIn} <= i[2:0];
      repeat (4) @(posedge clk);
      chk("monitor lines", {29'h0, i[0], i[2], i[1]}, {29'h0, digOut[2:0]});
    end
    {moveIn, zeroIn, rangeIn} <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      setWt <= wts[i];
      repeat (4) @(posedge clk);
      chk("over line", {31'h0, i == 0}, {31'h0, digOut[5]});
      rdChk("check status", bsse_pkg::OFF_STATUS, 32'h0006_0000, cws[i]);
    end
    setWt <= 24'h00_0000;
    $display("Test monitors done");
    apb(1'b1, bsse_pkg::OFF_REPEAT, 32'h0000_0002);
    moveIn <= 1'b1;
    run(32'h0000_00E3, 32'h0000_00E2, 32'h0000_0000, 32'h0000_0001);
    repeat (6) @(posedge clk);
    rdChk("held step", bsse_pkg::OFF_STATUS, 32'h0000_003F, 32'h0000_0009);
    chk("batch line on", 32'h0000_0001, {31'h0, digOut[3]});
    moveIn <= 1'b0;
    waitIrq();
    rdChk("passes", bsse_pkg::OFF_STATUS, 32'h0000_FF03, 32'h0000_0100);
    chk("batch line off", 32'h0000_0000, {31'h0, digOut[3]});
    rdChk("done flag", bsse_pkg::OFF_IRQ, 32'h0000_0001, 32'h0000_0001);
    rdChk("flag cleared", bsse_pkg::OFF_IRQ, 32'h0000_0001, 32'h0000_0000);
    $display("Test wait and repeat done");
    apb(1'b1, bsse_pkg::OFF_REPEAT, 32'h0000_0001);
    apb(1'b1, bsse_pkg::OFF_WDOG, 32'h0000_0002);
    moveIn <= 1'b1;
    run(32'h0000_00E2, 32'h0000_00E7, 32'h0000_0000, 32'h0000_0002);
    repeat (8) @(posedge clk);
    chk("watchdog early", 32'h0000_0000, {31'h0, digOut[4]});
    waitIrq();
    repeat (2) @(posedge clk);
    chk("watchdog line", 32'h0000_0001, {31'h0, digOut[4]});
    rdChk("watchdog flag", bsse_pkg::OFF_STATUS, 32'h0001_0000, 32'h0001_0000);
    apb(1'b1, bsse_pkg::OFF_CTRL, 32'h0000_0002);
    apb(1'b0, bsse_pkg::OFF_IRQ, 32'h0000_0000);
    apb(1'b1, bsse_pkg::OFF_WDOG, 32'h0000_00FF);
    $display("Test watchdog done");
    run(32'h0000_02E8, 32'h0000_00E2, 32'h0000_00E7, 32'h0000_0001);
    waitIrq();
    chk("branch done", 32'h0000_0001, {31'h0, irq});
    rdChk("branch idle", bsse_pkg::OFF_STATUS, 32'h0000_0003, 32'h0000_0000);
    apb(1'b0, bsse_pkg::OFF_IRQ, 32'h0000_0000);
    $display("Test branch done");
    moveIn <= 1'b0;
    setWt <= 24'h00_012C;
    run(32'h0001_90E6, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001);
    setWt <= 24'h00_014A;
    repeat (6) @(posedge clk);
    rdChk("delta short", bsse_pkg::OFF_STATUS, 32'h0000_0003, 32'h0000_0001);
    setWt <= 24'h00_015E;
    waitIrq();
    chk("delta met", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, bsse_pkg::OFF_IRQ, 32'h0000_0000);
    $display("Test delta done");
    setWt <= 24'h00_0000;
    repeat (2) @(posedge clk);
    setEn <= 1'b0;
    run(32'h0003_20D1, 32'h0000_00E4, 32'h0000_0000, 32'h0000_0001);
    waitIrq();
    rdChk("nudge flags", bsse_pkg::OFF_IRQ, 32'h0000_0009, 32'h0000_0009);
    chk("settled weight", 32'h0000_0001,
      {31'h0, scale.weight >= 24'h00_0064 && scale.standstill});
    setEn <= 1'b1;
    $display("Test nudge done");
    apb(1'b1, bsse_pkg::OFF_TIME, 32'h0000_0005);
    apb(1'b1, bsse_pkg::OFF_CLKSET, 32'h0000_0006);
    apb(1'b1, bsse_pkg::OFF_MASK, 32'h0000_0004);
    waitIrq();
    rdChk("clock match", bsse_pkg::OFF_IRQ, 32'h0000_0004, 32'h0000_0004);
    $display("Test clock done");
    print_verdict();
  end
endmodule
`default_nettype wire
